// [lcnc_pkg.sv]
// Constants and types for the LED correction and NVM control registers
// Summary of operation
// - Correction code scales level in 1/128 steps
// - Red multiplier read/write at 0x0a
// - Green multiplier read/write at 0x0b
// - Blue multiplier read/write at 0x0c
// - Control bit 7 is read-only ready flag
// - Writing one to bit 6 while idle starts erase
// - Writing one to bit 5 while idle, with bit 6 zero, starts programming
// - Two-bit page field selects 32-location window
`default_nettype none

package lcnc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] LCNC_OFS_RED   = 8'h0a;
  localparam logic [7:0] LCNC_OFS_GREEN = 8'h0b;
  localparam logic [7:0] LCNC_OFS_BLUE  = 8'h0c;
  localparam logic [7:0] LCNC_OFS_NVM   = 8'h0d;

  // ==========================================================================
  // Control register field positions
  localparam int LCNC_BIT_READY = 7;
  localparam int LCNC_BIT_WIPE  = 6;
  localparam int LCNC_BIT_WRITE = 5;
  localparam int LCNC_BIT_LOAD  = 4;
  localparam int LCNC_PAGE_LSB  = 0;
  localparam int LCNC_PAGE_W    = 2;

  // ==========================================================================
  // Reset values and scaling
  localparam logic [7:0] LCNC_CORR_RESET = 8'h80;
  localparam logic [1:0] LCNC_PAGE_RESET = 2'h0;
  localparam int         LCNC_CORR_SHIFT = 7;
  localparam int         LCNC_PAGE_SIZE  = 32;

  // ==========================================================================
  // Sequence states
  typedef enum logic [1:0] {
    LCNC_IDLE,
    LCNC_WIPE,
    LCNC_WRITE,
    LCNC_LOAD
  } lcnc_state_t;

endpackage : lcnc_pkg

`default_nettype wire

// [lcnc_regs.sv]
// Correction multiplier registers and NVM operation control
`default_nettype none

module lcnc_regs #(
  parameter int LEVEL_W = 8
) (
  // Clock, reset, enable
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               clockEnable,
  // Register port
  input  wire logic [7:0]         regAddr,
  input  wire logic               regWrite,
  input  wire logic [7:0]         regWriteData,
  input  wire logic               regRead,
  output logic [7:0]              regReadData,
  // Channel levels, index 0 red, 1 green, 2 blue
  input  wire logic [LEVEL_W-1:0] baseLevel [3],
  output logic [LEVEL_W:0]        correctedLevel [3],
  output logic [7:0]              correctionCode [3],
  // Memory sequencer
  output logic                    nvmWipeReq,
  output logic                    nvmWriteReq,
  output logic                    nvmLoadReq,
  output logic [6:0]              nvmWindowBase,
  output logic [lcnc_pkg::LCNC_PAGE_W-1:0] nvmWindowSelect,
  output logic                    nvmDoneFlag,
  input  wire logic               nvmOpDone
);
  import lcnc_pkg::*;

  // ==========================================================================
  // Decode helper
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ==========================================================================
  // Correction multipliers
  logic [7:0] corr      [3];
  logic [7:0] next_corr [3];
  localparam logic [7:0] CORR_OFS [3] = '{LCNC_OFS_RED, LCNC_OFS_GREEN, LCNC_OFS_BLUE};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      logic [LEVEL_W+7:0] product;
      logic [LEVEL_W:0]   next_level;

      always_comb begin
        next_corr[ch] = corr[ch];
        if (regWrite && hit(regAddr, CORR_OFS[ch])) begin
          next_corr[ch] = regWriteData;
        end
        product    = (LEVEL_W+8)'(baseLevel[ch]) * (LEVEL_W+8)'(corr[ch]);
        next_level = product[LEVEL_W+LCNC_CORR_SHIFT:LCNC_CORR_SHIFT];
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          corr[ch]           <= LCNC_CORR_RESET;
          correctedLevel[ch] <= '0;
          correctionCode[ch] <= LCNC_CORR_RESET;
        end else if (clockEnable) begin
          corr[ch]           <= next_corr[ch];
          correctedLevel[ch] <= next_level;
          correctionCode[ch] <= next_corr[ch];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // NVM operation sequencer
  lcnc_state_t                state;
  lcnc_state_t                next_state;
  logic [LCNC_PAGE_W-1:0]     page;
  logic [LCNC_PAGE_W-1:0]     next_page;
  logic                       next_wipeReq;
  logic                       next_writeReq;
  logic                       next_loadReq;
  logic                       ctrlWrite;

  always_comb begin
    ctrlWrite     = regWrite && hit(regAddr, LCNC_OFS_NVM);
    next_state    = state;
    next_page     = page;
    next_wipeReq  = 1'b0;
    next_writeReq = 1'b0;
    next_loadReq  = 1'b0;
    if (ctrlWrite) begin
      next_page = regWriteData[LCNC_PAGE_LSB +: LCNC_PAGE_W];
    end
    case (state)
      LCNC_IDLE: begin
        if (ctrlWrite && regWriteData[LCNC_BIT_WIPE]) begin
          next_state   = LCNC_WIPE;
          next_wipeReq = 1'b1;
        end else if (ctrlWrite && regWriteData[LCNC_BIT_WRITE]) begin
          next_state    = LCNC_WRITE;
          next_writeReq = 1'b1;
        end else if (ctrlWrite && regWriteData[LCNC_BIT_LOAD]) begin
          next_state   = LCNC_LOAD;
          next_loadReq = 1'b1;
        end
      end
      LCNC_WIPE, LCNC_WRITE, LCNC_LOAD: begin
        if (nvmOpDone) begin
          next_state = LCNC_IDLE;
        end
      end
      default: begin
        next_state = LCNC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state           <= LCNC_IDLE;
      page            <= LCNC_PAGE_RESET;
      nvmWipeReq      <= 1'b0;
      nvmWriteReq     <= 1'b0;
      nvmLoadReq      <= 1'b0;
      nvmWindowSelect <= LCNC_PAGE_RESET;
      nvmWindowBase   <= '0;
      nvmDoneFlag     <= 1'b1;
    end else if (clockEnable) begin
      state           <= next_state;
      page            <= next_page;
      nvmWipeReq      <= next_wipeReq;
      nvmWriteReq     <= next_writeReq;
      nvmLoadReq      <= next_loadReq;
      nvmWindowSelect <= next_page;
      nvmWindowBase   <= 7'(next_page * LCNC_PAGE_SIZE);
      nvmDoneFlag     <= (next_state == LCNC_IDLE);
    end
  end

  // ==========================================================================
  // Read path
  logic [7:0] next_readData;
  logic [7:0] ctrlView;

  always_comb begin
    ctrlView                                  = 8'h00;
    ctrlView[LCNC_BIT_READY]                  = (state == LCNC_IDLE);
    ctrlView[LCNC_BIT_WIPE]                   = (state == LCNC_WIPE);
    ctrlView[LCNC_BIT_WRITE]                  = (state == LCNC_WRITE);
    ctrlView[LCNC_BIT_LOAD]                   = (state == LCNC_LOAD);
    ctrlView[LCNC_PAGE_LSB +: LCNC_PAGE_W]    = page;
    next_readData = regReadData;
    if (regRead) begin
      if (hit(regAddr, LCNC_OFS_RED)) begin
        next_readData = corr[0];
      end else if (hit(regAddr, LCNC_OFS_GREEN)) begin
        next_readData = corr[1];
      end else if (hit(regAddr, LCNC_OFS_BLUE)) begin
        next_readData = corr[2];
      end else if (hit(regAddr, LCNC_OFS_NVM)) begin
        next_readData = ctrlView;
      end else begin
        next_readData = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (clockEnable) begin
      regReadData <= next_readData;
    end
  end

endmodule : lcnc_regs

`default_nettype wire

// [lcnc_regs_asserts.sv]
// Checker for the correction and memory control registers
`default_nettype none
module lcnc_regs_chk
  import lcnc_pkg::*;
#(parameter int LEVEL_W = 8) (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   reset,
  // Register port
  input wire logic                   clockEnable,
  input wire logic [7:0]             regAddr,
  input wire logic                   regWrite,
  input wire logic [7:0]             regWriteData,
  input wire logic                   regRead,
  input wire logic [7:0]             regReadData,
  // Memory sequencer
  input wire logic                   nvmWipeReq,
  input wire logic                   nvmWriteReq,
  input wire logic                   nvmLoadReq,
  input wire logic [6:0]             nvmWindowBase,
  input wire logic [LCNC_PAGE_W-1:0] nvmWindowSelect,
  input wire logic                   nvmDoneFlag,
  input wire logic                   nvmOpDone
);
  // ====
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_ctl_wr;
    clockEnable && regWrite && regAddr == LCNC_OFS_NVM;
  endsequence
  sequence s_idle_wr;
    s_ctl_wr ##0 nvmDoneFlag;
  endsequence
  chk_wipe_start: assert property (
    s_idle_wr ##0 regWriteData[6] |=> nvmWipeReq && !nvmDoneFlag) else $error("no erase");
  chk_prog_start: assert property (
    s_idle_wr ##0 regWriteData[6:5] == 2'h1 |=> nvmWriteReq && !nvmWipeReq) else $error("no prog");
  chk_load_start: assert property (
    s_idle_wr ##0 regWriteData[6:4] == 3'h1 |=> nvmLoadReq ##1 !nvmLoadReq) else $error("no load");
  chk_ready_ro: assert property (
    s_idle_wr ##0 regWriteData[6:4] == 3'h0 |=> nvmDoneFlag) else $error("ready changed");
  chk_busy_hold: assert property (
    !nvmDoneFlag && !nvmOpDone |=> !nvmDoneFlag) else $error("ready too early");
  chk_done_return: assert property (
    clockEnable && !nvmDoneFlag && nvmOpDone |=> nvmDoneFlag) else $error("ready missing");
  chk_page_write: assert property (
    s_ctl_wr |=> nvmWindowSelect == 2'($past(regWriteData))) else $error("page wrong");
  chk_page_base: assert property (
    nvmWindowBase == {nvmWindowSelect, 5'h0}) else $error("window base wrong");
  chk_unmapped_read: assert property (
    clockEnable && regRead && (regAddr < 8'h0a || regAddr > 8'h0d) |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
endmodule : lcnc_regs_chk
bind lcnc_regs lcnc_regs_chk #(.LEVEL_W(LEVEL_W)) i_chk (.clock, .reset, .clockEnable,
  .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .nvmWipeReq, .nvmWriteReq,
  .nvmLoadReq, .nvmWindowBase, .nvmWindowSelect, .nvmDoneFlag, .nvmOpDone);
`default_nettype wire

// [tb.sv]
// Self-checking bench for the correction and memory control registers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lcnc_pkg::*;
  logic       clock, reset, clockEnable, regWrite, regRead, nvmOpDone, rdFlag, s0, s1, s2;
  logic       doneFlag;
  logic [7:0] regAddr, regWriteData, regReadData, st, code [3], baseLevel [3], correctionCode [3];
  logic [8:0] correctedLevel [3], expQ [$];
  logic [6:0] nvmWindowBase;
  logic [1:0] nvmWindowSelect;
  int         errTotal = 0, nCompared = 0, cycles = 0;
  lcnc_regs i_dut (.clock, .reset, .clockEnable, .regAddr, .regWrite, .regWriteData, .regRead,
    .regReadData, .baseLevel, .correctedLevel, .correctionCode, .nvmWipeReq(s0),
    .nvmWriteReq(s1), .nvmLoadReq(s2), .nvmWindowBase, .nvmWindowSelect, .nvmDoneFlag(doneFlag),
    .nvmOpDone);
  // ====
  // Tasks
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({1'b0, e});
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
  endtask : rd
  task automatic opDone;
    @(posedge clock);
    nvmOpDone <= 1'b1;
    @(posedge clock);
    nvmOpDone <= 1'b0;
  endtask : opDone
  task endOfTest;
    $display("compared %0d, errors %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : endOfTest
  // ====
  // Clock, monitor and timeout
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rdFlag) cmp({1'b0, regReadData}, expQ.pop_front());
    rdFlag <= regRead && clockEnable;
    cycles++;
    if (cycles > 3000) begin
      errTotal++;
      endOfTest();
    end
  end
  // ====
  // Stimulus
  initial begin
    {reset, clockEnable} = 2'h3;
    {regWrite, regRead, nvmOpDone, rdFlag, regAddr, regWriteData} = '0;
    void'($urandom(32'h98262ce1));
    for (int i = 0; i < 3; i++) baseLevel[i] = 8'($urandom);
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rd(8'h0a + 8'(i), 8'h80);
    wr(8'h0e, 8'hff);
    rd(8'h0e, 8'h00);
    for (int i = 0; i < 3; i++) begin
      code[i] = 8'($urandom);
      wr(LCNC_OFS_RED + 8'(i), code[i]);
      rd(LCNC_OFS_RED + 8'(i), code[i]);
    end
    repeat (3) @(posedge clock);
    for (int i = 0; i < 3; i++) cmp(correctedLevel[i], 9'((16'(baseLevel[i]) * code[i]) >> 7));
    for (int i = 0; i < 3; i++) cmp({1'b0, correctionCode[i]}, {1'b0, code[i]});
    @(posedge clock);
    clockEnable <= 1'b0;
    wr(LCNC_OFS_RED, ~code[0]);
    clockEnable <= 1'b1;
    rd(LCNC_OFS_RED, code[0]);
    for (int i = 0; i < 3; i++) begin
      st = (8'h40 >> i) | 8'(i + 1);
      wr(LCNC_OFS_NVM, st);
      rd(LCNC_OFS_NVM, st);
      #1 cmp({8'h00, doneFlag}, 9'h000);
      wr(LCNC_OFS_NVM, 8'hf0);
      rd(LCNC_OFS_NVM, st & 8'h70);
      opDone();
      rd(LCNC_OFS_NVM, 8'h80);
    end
    wr(LCNC_OFS_NVM, 8'h03);
    rd(LCNC_OFS_NVM, 8'h83);
    repeat (2) @(posedge clock);
    #1 cmp({8'h00, doneFlag}, 9'h001);
    cmp({2'b00, nvmWindowBase}, 9'h060);
    cmp({7'h00, nvmWindowSelect}, 9'h003);
    endOfTest();
  end
endmodule : tb
`default_nettype wire
